// >>> test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: got %h", $time, a); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic [1:0] opc = 2'h0;
  logic [7:0] dat = 8'h00;
  logic net = 1'b0;
  logic brk = 1'b0;
  logic busy = 1'b0;
  logic txd = 1'b0;
  logic rxv = 1'b0;
  logic rxc = 1'b0;
  logic [7:0] rxd = 8'h00;
  logic take = 1'b0;
  logic ready, rdv, sreq, txv, txl, quad, wave, retry, crun, lowp;
  logic [7:0] rdd, txdat, rd, b, cfg;
  vpw_pkg::vpw_mode_type mode;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  int checks = 0;
  int fails = 0;
  int seed;
  always #10 clk = ~clk;
  vpw_host_if u_vpw_host_if ();
  vpw_host_end u_vpw_host_end (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .hif(u_vpw_host_if),
    .i_req_valid(valid), .i_req_op(opc), .i_req_data(dat), .o_req_ready(ready), .o_rd_data(rdd),
    .o_rd_valid(rdv), .o_service_req(sreq));
  vpw_dev_end u_vpw_dev_end (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .hif(u_vpw_host_if),
    .i_net_activity(net), .i_break_rx(brk), .i_frame_busy(busy), .i_tx_done(txd), .i_rx_valid(rxv),
    .i_rx_data(rxd), .i_rx_code(rxc), .i_tx_take(take), .o_tx_valid(txv), .o_tx_data(txdat),
    .o_tx_last(txl), .o_mode(mode), .o_quad_speed(quad), .o_waveshape_en(wave),
    .o_retry_term(retry), .o_clk_run(crun), .o_phy_low_power(lowp));
  vpw_link_asserts u_vpw_link_asserts (.i_clk_sys(clk), .i_rst_n(rst_n),
    .bus_clk(u_vpw_host_if.bus_clk), .cs_n(u_vpw_host_if.cs_n),
    .byte_select(u_vpw_host_if.byte_select), .rd_wr(u_vpw_host_if.rd_wr),
    .host_data_oe(u_vpw_host_if.host_data_oe), .dev_data(u_vpw_host_if.dev_data),
    .dev_data_oe(u_vpw_host_if.dev_data_oe), .srq_n(u_vpw_host_if.srq_n),
    .power_switch_enable_oe(u_vpw_host_if.power_switch_enable_oe));
  // Mode the device should settle in after a configuration byte
  function automatic vpw_pkg::vpw_mode_type exp_mode(input logic [7:0] c);
    return c[vpw_pkg::CFG_QUAD_BIT] ? vpw_pkg::VPW_MODE_QUAD : vpw_pkg::VPW_MODE_NORMAL;
  endfunction : exp_mode
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic bound(input int n);
    if (n >= 99) begin
      fails++;
      $display("unexpected at %0t: timeout", $time);
      finish_test();
    end
  endtask : bound
  // Edges until host port is ready; catches read data on the way
  task automatic to_ready();
    int n;
    n = 0;
    do begin @(posedge clk); n++; if (rdv === 1'b1) rd = rdd; end while (ready !== 1'b1 && n < 99);
    bound(n);
  endtask : to_ready
  task automatic op(input logic [1:0] c, input logic [7:0] d);
    valid <= 1'b1;
    opc <= c;
    dat <= d;
    to_ready();
    valid <= 1'b0;
    to_ready();
  endtask : op
  // Command byte always followed by its companion byte
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    op(vpw_pkg::OP_WR_CMD, c);
    op(vpw_pkg::OP_WR_DATA, d);
  endtask : wr
  task automatic take_one(input logic lastx);
    int n;
    n = 0;
    while (txv !== 1'b1 && n < 99) begin @(posedge clk); n++; end
    bound(n);
    `CHK(txdat, txq.pop_front());
    `CHK(txl, lastx);
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : take_one
  initial begin
    seed = 93;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(mode, vpw_pkg::VPW_MODE_RESET);
    `CHK(u_vpw_host_if.power_switch_enable_oe, 1'b1);
    wr(vpw_pkg::CMD_NULL, 8'($random(seed)));
    op(vpw_pkg::OP_WR_CMD, vpw_pkg::CMD_CONFIG);
    `CHK(mode, vpw_pkg::VPW_MODE_RESET);
    op(vpw_pkg::OP_WR_DATA, 8'h00);
    `CHK(mode, vpw_pkg::VPW_MODE_NORMAL);
    // Random mask and interrupt mode bits, quad bit alternates so both exits are seen
    for (int i = 0; i < 4; i++) begin
      cfg = {5'h00, 2'($random(seed)), i[0]};
      wr(vpw_pkg::CMD_CONFIG, cfg);
      `CHK(mode, exp_mode(cfg));
      `CHK(wave, ~cfg[0]);
      `CHK(quad, cfg[0]);
    end
    op(vpw_pkg::OP_RD_STATUS, 8'h00);
    `CHK(rd[vpw_pkg::ST_QUAD_BIT], 1'b1);
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(mode, vpw_pkg::VPW_MODE_NORMAL);
    $display("modes test done");
    b = 8'($random(seed));
    txq.push_back(b);
    wr(vpw_pkg::CMD_TX_FIRST_LAST, b);
    take_one(1'b1);
    for (int i = 0; i < vpw_pkg::TXQ_DEPTH_DEF; i++) begin
      b = 8'($random(seed));
      txq.push_back(b);
      if (i == 0) wr(vpw_pkg::CMD_TX_FIRST, b);
      else if (i == 1) wr(vpw_pkg::CMD_TX_MID, b);
      else op(vpw_pkg::OP_WR_DATA, b);
    end
    `CHK(mode, vpw_pkg::VPW_MODE_BLOCK);
    `CHK(retry, 1'b1);
    take_one(1'b0);
    b = 8'($random(seed));
    txq.push_back(b);
    wr(vpw_pkg::CMD_TX_LAST, b);
    `CHK(mode, vpw_pkg::VPW_MODE_NORMAL);
    repeat (7) take_one(1'b0);
    take_one(1'b1);
    wr(vpw_pkg::CMD_TERM_RETRY, 8'h00);
    `CHK(retry, 1'b1);
    `CHK(mode, vpw_pkg::VPW_MODE_NORMAL);
    $display("transmit test done");
    // First received byte is flagged as a completion code
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      rxq.push_back(b);
      rxd <= b;
      rxc <= (k == 0);
      rxv <= 1'b1;
      @(posedge clk);
      rxv <= 1'b0;
      @(posedge clk);
    end
    op(vpw_pkg::OP_RD_STATUS, 8'h00);
    `CHK(rd[vpw_pkg::ST_RX_AVAIL_BIT], 1'b1);
    `CHK(rd[vpw_pkg::ST_RX_CODE_BIT], 1'b1);
    repeat (3) begin
      op(vpw_pkg::OP_RD_DATA, 8'h00);
      `CHK(rd, rxq.pop_front());
    end
    op(vpw_pkg::OP_RD_DATA, 8'h00);
    `CHK(rd, 8'h00);
    $display("receive test done");
    // Request raised, read back, then masked
    for (int i = 0; i < 2; i++) begin
      wr(vpw_pkg::CMD_CONFIG, i[0] ? 8'h02 : 8'h00);
      op(vpw_pkg::OP_RD_STATUS, 8'h00);
      txd <= 1'b1;
      @(posedge clk);
      txd <= 1'b0;
      repeat (12) @(posedge clk);
      `CHK(sreq, ~i[0]);
      op(vpw_pkg::OP_RD_STATUS, 8'h00);
      `CHK(sreq, 1'b0);
    end
    $display("request test done");
    busy <= 1'b1;
    wr(vpw_pkg::CMD_STANDBY, 8'h00);
    `CHK(mode, vpw_pkg::VPW_MODE_NORMAL);
    busy <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(mode, vpw_pkg::VPW_MODE_STANDBY);
    `CHK(u_vpw_host_if.power_switch_enable_oe, 1'b0);
    `CHK({crun, lowp}, 2'h1);
    net <= 1'b1;
    @(posedge clk);
    net <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(mode, vpw_pkg::VPW_MODE_NORMAL);
    wr(vpw_pkg::CMD_STANDBY, 8'h00);
    op(vpw_pkg::OP_RD_STATUS, 8'h00);
    `CHK(mode, vpw_pkg::VPW_MODE_NORMAL);
    $display("standby test done");
    rst_n <= 1'b0;
    @(posedge clk);
    `CHK(mode, vpw_pkg::VPW_MODE_RESET);
    rst_n <= 1'b1;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire

// >>> test/vpw_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module vpw_link_asserts (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic bus_clk,
  input wire logic cs_n,
  input wire logic byte_select,
  input wire logic rd_wr,
  input wire logic host_data_oe,
  input wire logic [7:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic srq_n,
  input wire logic power_switch_enable_oe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] lo_reg;
  // Cycles with select low; device sees select some cycles late
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) lo_reg <= 4'h0;
    else if (cs_n) lo_reg <= 4'h0;
    else if (lo_reg != 4'hf) lo_reg <= lo_reg + 4'h1;
  end
  a_no_bus_fight: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive data");
  a_release_lines: assert property ($rose(cs_n) |-> ##[1:8] !dev_data_oe)
    else $error("data lines kept after deselect");
  a_read_only_drive: assert property (lo_reg >= 4'h6 && !rd_wr |-> !dev_data_oe)
    else $error("device drives during write");
  a_status_frozen: assert property (lo_reg >= 4'h8 && dev_data_oe && !byte_select && rd_wr
    |-> $stable(dev_data))
    else $error("status moved under select");
  a_srq_held_off: assert property (lo_reg >= 4'h6 && srq_n |=> srq_n)
    else $error("request raised under select");
  a_srq_clear: assert property (!cs_n && !byte_select && rd_wr && $rose(bus_clk)
    |-> ##[1:10] srq_n)
    else $error("request kept after status read");
  a_wake_status: assert property (!cs_n && !byte_select && rd_wr && $rose(bus_clk)
    |-> ##[1:12] power_switch_enable_oe)
    else $error("no wake on status read");
  a_clk_framed: assert property ($fell(cs_n) |-> ##[6:9] $rose(bus_clk) ##[3:5] $fell(bus_clk)
    ##[3:5] $rose(cs_n))
    else $error("bus clock frame wrong");
  a_clk_idle: assert property (cs_n |-> !bus_clk)
    else $error("bus clock runs while idle");
  // Main scenarios reached
  c_status_read: cover property (!cs_n && !byte_select && rd_wr && $rose(bus_clk));
  c_standby: cover property ($fell(power_switch_enable_oe));
  c_request: cover property ($fell(srq_n));
endmodule : vpw_link_asserts
`default_nettype wire

// >>> verilog/vpw_dev_end.sv
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module vpw_dev_end #(
  parameter int TXQ_DEPTH = vpw_pkg::TXQ_DEPTH_DEF,
  parameter int RXQ_DEPTH = vpw_pkg::RXQ_DEPTH_DEF,
  parameter int RXQ_THRESH = vpw_pkg::RXQ_THRESH_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  vpw_host_if.device hif,
  input wire logic i_net_activity,
  input wire logic i_break_rx,
  input wire logic i_frame_busy,
  input wire logic i_tx_done,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_code,
  input wire logic i_tx_take,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_tx_last,
  output vpw_pkg::vpw_mode_type o_mode,
  output logic o_quad_speed,
  output logic o_waveshape_en,
  output logic o_retry_term,
  output logic o_clk_run,
  output logic o_phy_low_power
);
  localparam int TXW = $clog2(TXQ_DEPTH);
  localparam int RXW = $clog2(RXQ_DEPTH);
  localparam int TXC = $clog2(TXQ_DEPTH + 1);
  localparam int RXC = $clog2(RXQ_DEPTH + 1);
  localparam logic [TXC-1:0] TX_FULL_CNT = TXC'(TXQ_DEPTH);
  localparam logic [RXC-1:0] RX_FULL_CNT = RXC'(RXQ_DEPTH);
  localparam logic [RXC-1:0] RX_THR_CNT = RXC'(RXQ_THRESH);

  // Pins from the host side, filtered through three stages
  logic [11:0] pins_q;
  logic clk_q, cs_n_q, sel_q, rw_q;
  logic [7:0] dat_q;
  logic clk_d_reg;
  // Reset value is the idle bus: clock low, deselected, read, data pulled high
  vpw_sync #(.WIDTH(12), .RST_VAL(12'h5ff)) u_pin_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({hif.bus_clk, hif.cs_n, hif.byte_select, hif.rd_wr, hif.data_bus}),
    .o_sync(pins_q)
  );
  assign {clk_q, cs_n_q, sel_q, rw_q, dat_q} = pins_q;

  vpw_pkg::vpw_mode_type mode_reg;
  logic [7:0] cfg_reg;
  logic [7:0] cmd_reg;
  logic cmd_pend_reg;
  logic standby_req_reg;
  logic term_reg;
  logic break_seen_reg;
  logic [7:0] status_frz_reg;
  logic srq_pend_reg;
  logic [8:0] txq_mem [TXQ_DEPTH];
  logic [TXW-1:0] tx_wr_reg, tx_rd_reg;
  logic [TXC-1:0] tx_cnt_reg;
  logic last_queued_reg;
  logic [8:0] rxq_mem [RXQ_DEPTH];
  logic [RXW-1:0] rx_wr_reg, rx_rd_reg;
  logic [RXC-1:0] rx_cnt_reg;

  function automatic logic [TXW-1:0] tx_inc(input logic [TXW-1:0] p);
    tx_inc = (p == TXW'(TXQ_DEPTH - 1)) ? '0 : TXW'(p + 1'b1);
  endfunction : tx_inc

  function automatic logic [RXW-1:0] rx_inc(input logic [RXW-1:0] p);
    rx_inc = (p == RXW'(RXQ_DEPTH - 1)) ? '0 : RXW'(p + 1'b1);
  endfunction : rx_inc

  function automatic logic is_tx_cmd(input logic [7:0] c);
    is_tx_cmd = (c == vpw_pkg::CMD_TX_FIRST) || (c == vpw_pkg::CMD_TX_MID) ||
                (c == vpw_pkg::CMD_TX_LAST) || (c == vpw_pkg::CMD_TX_FIRST_LAST);
  endfunction : is_tx_cmd

  // Transfer decode, one transfer per bus clock rise under select
  logic xfer, wr_cmd, rd_status, wr_data, rd_data;
  logic [1:0] op;
  logic [7:0] exe_cmd;
  logic push_tx, last_push, cfg_load, pop_tx, push_rx, pop_rx;
  logic tx_full, tx_empty, standby_go;
  logic [7:0] status_live;
  assign xfer = clk_q & ~clk_d_reg & ~cs_n_q;
  assign op = {sel_q, rw_q};
  assign wr_cmd = xfer && (op == vpw_pkg::OP_WR_CMD);
  assign rd_status = xfer && (op == vpw_pkg::OP_RD_STATUS);
  assign wr_data = xfer && (op == vpw_pkg::OP_WR_DATA);
  assign rd_data = xfer && (op == vpw_pkg::OP_RD_DATA);
  // Without a pending command a data byte is an intermediate byte
  assign exe_cmd = cmd_pend_reg ? cmd_reg : vpw_pkg::CMD_TX_MID;
  assign tx_full = (tx_cnt_reg == TX_FULL_CNT);
  assign tx_empty = (tx_cnt_reg == '0);
  assign push_tx = wr_data && is_tx_cmd(exe_cmd) && !tx_full;
  assign last_push = push_tx && ((exe_cmd == vpw_pkg::CMD_TX_LAST) ||
                                 (exe_cmd == vpw_pkg::CMD_TX_FIRST_LAST));
  assign cfg_load = wr_data && (exe_cmd == vpw_pkg::CMD_CONFIG);
  assign pop_tx = i_tx_take && o_tx_valid;
  assign push_rx = i_rx_valid && (rx_cnt_reg != RX_FULL_CNT);
  assign pop_rx = rd_data && (rx_cnt_reg != '0);
  assign standby_go = standby_req_reg && !i_frame_busy && tx_empty;

  always_comb begin
    status_live = 8'h00;
    status_live[vpw_pkg::ST_RX_AVAIL_BIT] = (rx_cnt_reg != '0);
    status_live[vpw_pkg::ST_RX_CODE_BIT] = (rx_cnt_reg != '0) && rxq_mem[rx_rd_reg][8];
    status_live[vpw_pkg::ST_TX_FULL_BIT] = tx_full;
    status_live[vpw_pkg::ST_TX_EMPTY_BIT] = tx_empty;
    status_live[vpw_pkg::ST_QUAD_BIT] = (mode_reg == vpw_pkg::VPW_MODE_QUAD);
    status_live[vpw_pkg::ST_BLOCK_BIT] = (mode_reg == vpw_pkg::VPW_MODE_BLOCK);
    status_live[vpw_pkg::ST_BREAK_BIT] = break_seen_reg;
    status_live[vpw_pkg::ST_SRQ_BIT] = srq_pend_reg;
  end

  // Host front: edge tracking, frozen status, read data drive
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_d_reg <= 1'b0;
      status_frz_reg <= 8'h00;
      hif.dev_data <= 8'h00;
      hif.dev_data_oe <= 1'b0;
    end else if (i_ce) begin
      clk_d_reg <= clk_q;
      if (cs_n_q) begin
        status_frz_reg <= status_live;
      end
      hif.dev_data_oe <= ~cs_n_q & rw_q;
      if (!sel_q) begin
        hif.dev_data <= status_frz_reg;
      end else begin
        hif.dev_data <= (rx_cnt_reg != '0) ? rxq_mem[rx_rd_reg][7:0] : 8'h00;
      end
    end
  end

  // Command latch and execution on the companion byte
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_reg <= vpw_pkg::CMD_NULL;
      cmd_pend_reg <= 1'b0;
      cfg_reg <= vpw_pkg::CFG_RESET;
      standby_req_reg <= 1'b0;
      term_reg <= 1'b0;
      break_seen_reg <= 1'b0;
    end else if (i_ce) begin
      if (wr_cmd) begin
        cmd_reg <= dat_q;
        cmd_pend_reg <= 1'b1;
      end else if (wr_data) begin
        cmd_pend_reg <= 1'b0;
      end
      if (cfg_load) begin
        cfg_reg <= dat_q;
      end else if (i_break_rx) begin
        cfg_reg[vpw_pkg::CFG_QUAD_BIT] <= 1'b0;
      end
      if (wr_data && exe_cmd == vpw_pkg::CMD_STANDBY) begin
        standby_req_reg <= 1'b1;
      end else if (standby_go) begin
        standby_req_reg <= 1'b0;
      end
      if (wr_data && exe_cmd == vpw_pkg::CMD_TERM_RETRY) begin
        term_reg <= 1'b1;
      end else if (push_tx && exe_cmd == vpw_pkg::CMD_TX_FIRST) begin
        term_reg <= 1'b0;
      end
      // Set beats the clear from a status read
      break_seen_reg <= i_break_rx | (break_seen_reg & ~rd_status);
    end
  end

  // Transmit queue, entries carry a last-byte flag
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_cnt_reg <= '0;
      last_queued_reg <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_last <= 1'b0;
    end else if (i_ce) begin
      if (push_tx) begin
        txq_mem[tx_wr_reg] <= {last_push, dat_q};
        tx_wr_reg <= tx_inc(tx_wr_reg);
      end
      if (pop_tx) begin
        tx_rd_reg <= tx_inc(tx_rd_reg);
      end
      tx_cnt_reg <= TXC'(tx_cnt_reg + push_tx - pop_tx);
      if (last_push) begin
        last_queued_reg <= 1'b1;
      end else if (pop_tx && o_tx_last) begin
        last_queued_reg <= 1'b0;
      end
      // Head shown one cycle late; a take hides it for a cycle
      o_tx_valid <= !tx_empty && !pop_tx && mode_reg != vpw_pkg::VPW_MODE_STANDBY;
      o_tx_data <= txq_mem[tx_rd_reg][7:0];
      o_tx_last <= txq_mem[tx_rd_reg][8];
    end
  end

  // Receive queue, filled by the network side
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_cnt_reg <= '0;
    end else if (i_ce) begin
      if (push_rx) begin
        rxq_mem[rx_wr_reg] <= {i_rx_code, i_rx_data};
        rx_wr_reg <= rx_inc(rx_wr_reg);
      end
      if (pop_rx) begin
        rx_rd_reg <= rx_inc(rx_rd_reg);
      end
      rx_cnt_reg <= RXC'(rx_cnt_reg + push_rx - pop_rx);
    end
  end

  // Operating mode sequencing
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= vpw_pkg::VPW_MODE_RESET;
    end else if (i_ce) begin
      case (mode_reg)
        vpw_pkg::VPW_MODE_RESET: begin
          if (cfg_load) begin
            mode_reg <= dat_q[vpw_pkg::CFG_QUAD_BIT] ? vpw_pkg::VPW_MODE_QUAD : vpw_pkg::VPW_MODE_NORMAL;
          end
        end
        vpw_pkg::VPW_MODE_NORMAL: begin
          if (standby_go) begin
            mode_reg <= vpw_pkg::VPW_MODE_STANDBY;
          end else if (cfg_load && dat_q[vpw_pkg::CFG_QUAD_BIT]) begin
            mode_reg <= vpw_pkg::VPW_MODE_QUAD;
          end else if (tx_full && !last_queued_reg) begin
            mode_reg <= vpw_pkg::VPW_MODE_BLOCK;
          end
        end
        vpw_pkg::VPW_MODE_STANDBY: begin
          if (i_net_activity || rd_status) begin
            mode_reg <= vpw_pkg::VPW_MODE_NORMAL;
          end
        end
        vpw_pkg::VPW_MODE_QUAD: begin
          if (i_break_rx || (cfg_load && !dat_q[vpw_pkg::CFG_QUAD_BIT])) begin
            mode_reg <= vpw_pkg::VPW_MODE_NORMAL;
          end else if (standby_go) begin
            mode_reg <= vpw_pkg::VPW_MODE_STANDBY;
          end
        end
        vpw_pkg::VPW_MODE_BLOCK: begin
          if (last_push) begin
            mode_reg <= vpw_pkg::VPW_MODE_NORMAL;
          end
        end
        default: mode_reg <= vpw_pkg::VPW_MODE_RESET;
      endcase
    end
  end

  // Service request: sticky pending, gated by mask and select
  logic srq_event;
  assign srq_event = (push_rx && i_rx_code) || (push_rx && rx_cnt_reg == RX_THR_CNT - 1'b1) ||
                     i_tx_done || i_break_rx ||
                     (push_rx && cfg_reg[vpw_pkg::CFG_IMOD_BIT]);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      srq_pend_reg <= 1'b0;
      hif.srq_n <= 1'b1;
    end else if (i_ce) begin
      srq_pend_reg <= srq_event | (srq_pend_reg & ~rd_status);
      if (!cs_n_q) begin
        hif.srq_n <= hif.srq_n | rd_status;
      end else begin
        hif.srq_n <= !(srq_pend_reg && !cfg_reg[vpw_pkg::CFG_IMSK_BIT] &&
                       mode_reg != vpw_pkg::VPW_MODE_RESET);
      end
    end
  end

  // Mode-derived outputs; power switch floats only in standby
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_mode <= vpw_pkg::VPW_MODE_RESET;
      o_quad_speed <= 1'b0;
      o_waveshape_en <= 1'b1;
      o_retry_term <= 1'b0;
      o_clk_run <= 1'b1;
      o_phy_low_power <= 1'b0;
      hif.power_switch_enable <= 1'b1;
      hif.power_switch_enable_oe <= 1'b1;
    end else if (i_ce) begin
      o_mode <= mode_reg;
      o_quad_speed <= (mode_reg == vpw_pkg::VPW_MODE_QUAD);
      o_waveshape_en <= (mode_reg != vpw_pkg::VPW_MODE_QUAD);
      o_retry_term <= (mode_reg == vpw_pkg::VPW_MODE_BLOCK) | term_reg;
      o_clk_run <= (mode_reg != vpw_pkg::VPW_MODE_STANDBY);
      o_phy_low_power <= (mode_reg == vpw_pkg::VPW_MODE_STANDBY);
      hif.power_switch_enable <= 1'b1;
      hif.power_switch_enable_oe <= (mode_reg != vpw_pkg::VPW_MODE_STANDBY);
    end
  end
endmodule : vpw_dev_end
`default_nettype wire

// >>> verilog/vpw_host_end.sv
`timescale 1ns/100ps
`default_nettype none
module vpw_host_end (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  vpw_host_if.host hif,
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_op,
  input wire logic [7:0] i_req_data,
  output logic o_req_ready,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_service_req
);
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_GAP} vpw_hstate_type;

  vpw_hstate_type st_reg;
  logic [3:0] cnt_reg;
  logic [1:0] op_reg;
  logic [8:0] back_q;

  // Device data and request line come in from outside this clock
  vpw_sync #(.WIDTH(9), .RST_VAL(9'h1ff)) u_back_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_async({hif.srq_n, hif.data_bus}),
    .o_sync(back_q)
  );

  // One transfer: select and setup, one bus clock pulse, release
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= H_IDLE;
      cnt_reg <= '0;
      op_reg <= vpw_pkg::OP_RD_STATUS;
      o_req_ready <= 1'b0;
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
      hif.bus_clk <= 1'b0;
      hif.cs_n <= 1'b1;
      hif.byte_select <= 1'b0;
      hif.rd_wr <= 1'b1;
      hif.host_data <= 8'h00;
      hif.host_data_oe <= 1'b0;
    end else if (i_ce) begin
      o_rd_valid <= 1'b0;
      case (st_reg)
        H_IDLE: begin
          o_req_ready <= 1'b1;
          if (i_req_valid && o_req_ready) begin
            // Caller keeps the servicing order; ops issue as given
            op_reg <= i_req_op;
            hif.cs_n <= 1'b0;
            {hif.byte_select, hif.rd_wr} <= i_req_op;
            hif.host_data <= i_req_data;
            hif.host_data_oe <= ~i_req_op[0];
            o_req_ready <= 1'b0;
            cnt_reg <= 4'(vpw_pkg::HOST_SETUP_CYC - 1);
            st_reg <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (cnt_reg == '0) begin
            hif.bus_clk <= 1'b1;
            cnt_reg <= 4'(vpw_pkg::HOST_CLK_HALF_CYC - 1);
            st_reg <= H_HIGH;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        H_HIGH: begin
          if (cnt_reg == '0) begin
            // Read data taken at the fall: device drive lags its filter, pop follows the rise
            if (op_reg[0]) begin
              o_rd_data <= back_q[7:0];
              o_rd_valid <= 1'b1;
            end
            hif.bus_clk <= 1'b0;
            cnt_reg <= 4'(vpw_pkg::HOST_CLK_HALF_CYC - 1);
            st_reg <= H_LOW;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        H_LOW: begin
          if (cnt_reg == '0) begin
            hif.cs_n <= 1'b1;
            hif.host_data_oe <= 1'b0;
            cnt_reg <= 4'(vpw_pkg::HOST_SETUP_CYC - 1);
            st_reg <= H_GAP;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        H_GAP: begin
          // Gap lets the device see select released between transfers
          if (cnt_reg == '0) begin
            st_reg <= H_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  // Service request seen as a level, active high here
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_service_req <= 1'b0;
    end else if (i_ce) begin
      o_service_req <= ~back_q[8];
    end
  end
endmodule : vpw_host_end
`default_nettype wire

// >>> verilog/vpw_host_if.sv
`timescale 1ns/100ps
`default_nettype none
interface vpw_host_if;
  logic bus_clk;
  logic cs_n;
  logic byte_select;
  logic rd_wr;
  logic [7:0] host_data;
  logic host_data_oe;
  logic [7:0] dev_data;
  logic dev_data_oe;
  logic srq_n;
  logic power_switch_enable;
  logic power_switch_enable_oe;
  logic [7:0] data_bus;

  // Shared data wire, idles high as if pulled up
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);

  modport device (
    input bus_clk, cs_n, byte_select, rd_wr, data_bus,
    output dev_data, dev_data_oe, srq_n, power_switch_enable, power_switch_enable_oe
  );
  modport host (
    output bus_clk, cs_n, byte_select, rd_wr, host_data, host_data_oe,
    input data_bus, srq_n
  );
endinterface : vpw_host_if
`default_nettype wire

// >>> verilog/vpw_pkg.sv
package vpw_pkg;

  // Operating modes
  typedef enum logic [2:0] {
    VPW_MODE_RESET,
    VPW_MODE_NORMAL,
    VPW_MODE_STANDBY,
    VPW_MODE_QUAD,
    VPW_MODE_BLOCK
  } vpw_mode_type;

  // Command byte codes
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_CONFIG = 8'h10;
  localparam logic [7:0] CMD_TX_FIRST = 8'h20;
  localparam logic [7:0] CMD_TX_MID = 8'h30;
  localparam logic [7:0] CMD_TX_LAST = 8'h40;
  localparam logic [7:0] CMD_TX_FIRST_LAST = 8'h50;
  localparam logic [7:0] CMD_STANDBY = 8'h60;
  localparam logic [7:0] CMD_TERM_RETRY = 8'h70;

  // Configuration byte fields
  localparam int CFG_QUAD_BIT = 0;
  localparam int CFG_IMSK_BIT = 1;
  localparam int CFG_IMOD_BIT = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Status byte fields
  localparam int ST_RX_AVAIL_BIT = 0;
  localparam int ST_RX_CODE_BIT = 1;
  localparam int ST_TX_FULL_BIT = 2;
  localparam int ST_TX_EMPTY_BIT = 3;
  localparam int ST_QUAD_BIT = 4;
  localparam int ST_BLOCK_BIT = 5;
  localparam int ST_BREAK_BIT = 6;
  localparam int ST_SRQ_BIT = 7;

  // Transfer selectors {byte_select, read}
  localparam logic [1:0] OP_WR_CMD = 2'h0;
  localparam logic [1:0] OP_RD_STATUS = 2'h1;
  localparam logic [1:0] OP_WR_DATA = 2'h2;
  localparam logic [1:0] OP_RD_DATA = 2'h3;

  // Queue sizes
  localparam int TXQ_DEPTH_DEF = 8;
  localparam int RXQ_DEPTH_DEF = 16;
  localparam int RXQ_THRESH_DEF = 13;

  // Host bus clock timing
  localparam int SYS_CLK_NS = 20;
  localparam int HOST_CLK_HALF_NS = 80;
  localparam int HOST_CLK_HALF_CYC = (HOST_CLK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int HOST_SETUP_CYC = 2 * HOST_CLK_HALF_CYC;

endpackage : vpw_pkg

// >>> verilog/vpw_sync.sv
`timescale 1ns/100ps
`default_nettype none
module vpw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] agree;

  // A bit moves only once stages two and three agree
  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      o_sync <= RST_VAL;
    end else if (i_ce) begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      o_sync <= (s3_reg & agree) | (o_sync & ~agree);
    end
  end
endmodule : vpw_sync
`default_nettype wire
